/* File: core/sync_out_map.svh */
// offsets of flag bits, settings defaults and timing counts for sync out
`ifndef SYNC_OUT_MAP_SVH
`define SYNC_OUT_MAP_SVH

// bit positions inside the flag byte
`define SO_FOLLOW_BIT     0
`define SO_FIXED_BIT      1
`define SO_ACT_LOW_BIT    2
`define SO_UNITS_BIT      3
`define SO_ON_BEGIN_BIT   4
`define SO_ON_END_BIT     5
`define SO_PERIODIC_BIT   6

// settings held after reset (the delivered standard set)
`define SO_DEF_FLAGS      8'h00
`define SO_DEF_WIDTH      16'h0064
`define SO_DEF_PERIOD     16'h0001
`define SO_DEF_TOL_FULL   32'h00000000
`define SO_DEF_TOL_MICRO  8'h00

// timing: one microsecond in clock cycles
`define SO_US_NS          1000
`define SO_CLK_NS         8
`define SO_US_CYCLES      (`SO_US_NS / `SO_CLK_NS)

// largest step division mode (shift of the microstep count)
`define SO_MAX_DIV_MODE   8

`endif

/* File: core/sync_out_pkg.sv */
// types shared by the output synchronization pulse generator
package sync_out_pkg;

    // one full set of output synchronization settings
    typedef struct packed {
        logic [7:0]  out_sync_flag_mask;
        logic [15:0] pulse_width_setting;
        logic [15:0] pulse_period_setting;
        logic [31:0] target_window_full;
        logic [7:0]  target_window_microsteps;
    } sync_cfg_type;

    // motion state presented by the motion engine
    typedef struct packed {
        logic               moving;
        logic               step_tick;
        logic signed [31:0] pos_full;
        logic signed [15:0] pos_micro;
        logic signed [31:0] target_full;
        logic signed [15:0] target_micro;
        logic [3:0]         step_division_mode;
        logic               is_stepper;
    } motion_type;

endpackage

/* File: core/sync_output_pulse_gen.sv */
// output synchronization pulse generator driving one sync-out pin
`timescale 1ns/1ps
`include "sync_out_map.svh"

// Notes on behaviour
// - Follow flag set: the pin shows the pulse logic, else the fixed flag.
// - Follow flag clear: the pin sits statically at the fixed-level flag.
// - The active-low flag makes low the active pulse level, otherwise high.
// - Pulse width counts 16-bit microseconds, or steps with the units flag.
// - Enabled pulses fire when motion begins and when motion ends.
// - Periodic flag: a pulse each time the step count reaches the period.
// - Entering the full-step window around the target fires the stop pulse.
// - A stepper widens the window by a microstep part set by the mode.
// - Received settings are stored; a default set is held from reset.
// - Microstep size and fraction range follow the step division mode.
module sync_output_pulse_gen
    import sync_out_pkg::*;
#(
    parameter int US_CYCLES    = `SO_US_CYCLES,
    parameter int MAX_DIV_MODE = `SO_MAX_DIV_MODE
) (
    input  wire logic         sys_clk_in,
    input  wire logic         resetn_in,
    input  wire logic         cfg_load_in,
    input  wire sync_cfg_type cfg_in,
    input  wire motion_type   motion_in,
    output logic              sync_out_pin_out,
    output logic              pulse_active_out,
    output sync_cfg_type      cfg_out
);

    // below four cycles the microsecond ticks crowd each other; above
    // fifteen the microstep shift no longer fits the position width
    if (US_CYCLES < 4 || US_CYCLES > 65535 ||
        MAX_DIV_MODE < 0 || MAX_DIV_MODE > 15) begin
        $error("sync_output_pulse_gen: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // position in microsteps; the fraction is clamped to the mode's range
    function automatic logic signed [48:0] to_micro(
        input logic signed [32:0] full,
        input logic signed [15:0] micro,
        input logic [3:0]         mode
    );
        logic signed [48:0] wide;
        logic signed [16:0] lim;
        logic signed [16:0] frac;
        wide = 49'(full);
        lim  = 17'(17'sd1 <<< mode) - 17'sd1;
        frac = 17'(micro);
        if (frac > lim) begin
            frac = lim;
        end else if (frac < -lim) begin
            frac = -lim;
        end
        to_micro = (wide <<< mode) + 49'(frac);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // stored settings

    sync_cfg_type cfg;

    // settings are replaced whole on each load, so no half-updated set
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg <= '{`SO_DEF_FLAGS, `SO_DEF_WIDTH, `SO_DEF_PERIOD,
                     `SO_DEF_TOL_FULL, `SO_DEF_TOL_MICRO};
        end else if (cfg_load_in) begin
            cfg <= cfg_in;
        end
    end

    assign cfg_out = cfg;

    logic follow;
    logic fixed_level;
    logic active_low;
    logic units;
    logic on_begin;
    logic on_end;
    logic periodic;

    assign follow      = cfg.out_sync_flag_mask[`SO_FOLLOW_BIT];
    assign fixed_level = cfg.out_sync_flag_mask[`SO_FIXED_BIT];
    assign active_low  = cfg.out_sync_flag_mask[`SO_ACT_LOW_BIT];
    assign units       = cfg.out_sync_flag_mask[`SO_UNITS_BIT];
    assign on_begin    = cfg.out_sync_flag_mask[`SO_ON_BEGIN_BIT];
    assign on_end      = cfg.out_sync_flag_mask[`SO_ON_END_BIT];
    assign periodic    = cfg.out_sync_flag_mask[`SO_PERIODIC_BIT];

    ////////////////////////////////////////////////////////////////////////
    // target window

    logic [3:0]         mode;
    logic signed [48:0] pos_u;
    logic signed [48:0] tgt_u;
    logic signed [48:0] diff_u;
    logic signed [48:0] dist_u;
    logic signed [48:0] tol_u;
    logic               in_window;
    logic               was_in_window;

    // a DC motor has no microsteps: mode zero and no fractional part
    assign mode   = !motion_in.is_stepper ? 4'h0 :
                    (motion_in.step_division_mode > 4'(MAX_DIV_MODE)) ?
                    4'(MAX_DIV_MODE) : motion_in.step_division_mode;
    assign pos_u  = to_micro(33'(motion_in.pos_full),
                             motion_in.is_stepper ? motion_in.pos_micro : '0,
                             mode);
    assign tgt_u  = to_micro(33'(motion_in.target_full),
                             motion_in.is_stepper ? motion_in.target_micro : '0,
                             mode);
    assign diff_u = pos_u - tgt_u;
    assign dist_u = diff_u[48] ? -diff_u : diff_u;
    assign tol_u  = to_micro($signed({1'b0, cfg.target_window_full}),
                             motion_in.is_stepper ?
                             $signed({8'h00, cfg.target_window_microsteps}) :
                             16'sd0,
                             mode);
    assign in_window = (dist_u <= tol_u);

    // only the entry into the window fires, not every cycle inside it
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            was_in_window <= 1'b1;
        end else begin
            was_in_window <= in_window;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motion edges and periodic count

    logic        was_moving;
    logic [15:0] period_cnt;
    logic        begin_evt;
    logic        end_evt;
    logic        period_evt;
    logic        trigger;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            was_moving <= 1'b0;
        end else begin
            was_moving <= motion_in.moving;
        end
    end

    assign begin_evt  = on_begin && motion_in.moving && !was_moving;
    assign end_evt    = on_end && ((!motion_in.moving && was_moving) ||
                                   (in_window && !was_in_window));
    assign period_evt = periodic && motion_in.step_tick &&
                        (cfg.pulse_period_setting != 16'h0000) &&
                        (period_cnt + 16'h0001 >=
                         cfg.pulse_period_setting);
    assign trigger    = begin_evt || end_evt || period_evt;

    // steps since the last periodic pulse; restarts when disabled
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            period_cnt <= 16'h0000;
        end else if (!periodic || period_evt) begin
            period_cnt <= 16'h0000;
        end else if (motion_in.step_tick) begin
            period_cnt <= period_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // microsecond time base

    logic [15:0] us_cnt;
    logic        us_tick;

    // free running; the first microsecond of a pulse may be short by up
    // to US_CYCLES - 1 clock cycles, which keeps the divider shared by all pulses
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            us_cnt <= 16'h0000;
        end else if (us_tick) begin
            us_cnt <= 16'h0000;
        end else begin
            us_cnt <= us_cnt + 16'h0001;
        end
    end

    assign us_tick = (us_cnt == 16'(US_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // pulse width

    logic [15:0] remaining;
    logic        width_tick;

    assign width_tick = units ? motion_in.step_tick : us_tick;

    // a new trigger reloads the width, merging into one longer pulse
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            remaining <= 16'h0000;
        end else if (trigger) begin
            remaining <= cfg.pulse_width_setting;
        end else if (width_tick && remaining != 16'h0000) begin
            remaining <= remaining - 16'h0001;
        end
    end

    assign pulse_active_out = (remaining != 16'h0000);

    ////////////////////////////////////////////////////////////////////////
    // pin

    // registered so the pin never glitches on a settings change
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_out_pin_out <= 1'b0;
        end else if (follow) begin
            sync_out_pin_out <= pulse_active_out ^ active_low;
        end else begin
            sync_out_pin_out <= fixed_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_follow;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        follow && pulse_active_out |=> sync_out_pin_out == !$past(active_low);
    endproperty
    a_follow: assert property (p_follow)
        else $error("pin does not show the active pulse level");

    property p_fixed;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        !follow ##1 !follow |-> sync_out_pin_out == $past(fixed_level);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("pin does not hold the fixed level");

    property p_idle;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        follow && !pulse_active_out |=> sync_out_pin_out == $past(active_low);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle pin level wrong for polarity");

    property p_width_hold;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        !trigger && !width_tick |=> $stable(remaining);
    endproperty
    a_width_hold: assert property (p_width_hold)
        else $error("width count moved without its unit tick");

    property p_begin;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        on_begin && $rose(motion_in.moving) && !cfg_load_in &&
        cfg.pulse_width_setting != 16'h0000 |=> pulse_active_out;
    endproperty
    a_begin: assert property (p_begin)
        else $error("no pulse at motion begin");

    property p_arrive;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        on_end && in_window && !was_in_window &&
        cfg.pulse_width_setting != 16'h0000 |=> pulse_active_out;
    endproperty
    a_arrive: assert property (p_arrive)
        else $error("no pulse on entering the target window");

    property p_period;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        period_evt |=> period_cnt == 16'h0000 && remaining != 16'h0000 ||
                       $past(cfg.pulse_width_setting) == 16'h0000;
    endproperty
    a_period: assert property (p_period)
        else $error("periodic pulse missing or count not restarted");

    property p_store;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        cfg_load_in |=> cfg_out == $past(cfg_in);
    endproperty
    a_store: assert property (p_store)
        else $error("settings not stored on load");

    property p_merge;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        trigger |=> remaining == $past(cfg.pulse_width_setting);
    endproperty
    a_merge: assert property (p_merge)
        else $error("width not restarted at latest trigger");

    property p_us_space;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        us_tick |=> !us_tick [*3];
    endproperty
    a_us_space: assert property (p_us_space)
        else $error("microsecond ticks too close");

endmodule

/* File: bench/sync_pulse_receiver.sv */
// behavioural instrument that counts the sync pulses it receives
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module sync_pulse_receiver (
    input  wire logic sys_clk_in,
    input  wire logic resetn_in,
    input  wire logic sync_in,
    input  wire logic active_low_in,
    output int        pulse_count_out
);
    logic prev_level;

    // count entries into the active level; a polarity change can look
    // like an edge, so the bench takes a baseline after each load
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_level      <= 1'b0;
            pulse_count_out <= 0;
        end else begin
            prev_level <= sync_in ^ active_low_in;
            if ((sync_in ^ active_low_in) && !prev_level) begin
                pulse_count_out <= pulse_count_out + 1;
            end
        end
    end
endmodule

/* File: bench/sync_output_pulse_gen_tb.sv */
// self-checking bench of the output synchronization pulse generator
`timescale 1ns/1ps
`include "sync_out_map.svh"

////////////////////////////////////////////////////////////////////////
module sync_output_pulse_gen_tb
    import sync_out_pkg::*;
;
    localparam int US = 4; // short microsecond keeps pulses quick
    logic         sys_clk_in;
    logic         resetn_in;
    logic         cfg_load_in;
    sync_cfg_type cfg_in;
    motion_type   motion_in;
    logic         sync_out_pin_out;
    logic         pulse_active_out;
    sync_cfg_type cfg_out;
    int           rx_count;
    int           failures;
    int           n_tests;
    int           base;
    int           n;
    int           w;
    int           p;
    logic [31:0]  seed;

    sync_output_pulse_gen #(.US_CYCLES(US), .MAX_DIV_MODE(8)) DUT (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .cfg_load_in(cfg_load_in), .cfg_in(cfg_in),
        .motion_in(motion_in), .sync_out_pin_out(sync_out_pin_out),
        .pulse_active_out(pulse_active_out), .cfg_out(cfg_out));

    sync_pulse_receiver rx (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .sync_in(sync_out_pin_out),
        .active_low_in(cfg_in.out_sync_flag_mask[`SO_ACT_LOW_BIT]),
        .pulse_count_out(rx_count));

    // free running clock, 8 ns period
    always #4 sys_clk_in = ~sys_clk_in;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic end_of_test();
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cfg(input sync_cfg_type got, input sync_cfg_type exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // inputs move only at the falling edge
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_in);
    endtask

    // whole settings set in one go, as the host request carries it
    task automatic load(input logic [7:0] f, input logic [15:0] wd,
                        input logic [15:0] pd, input logic [31:0] tf,
                        input logic [7:0] tm);
        cyc(1);
        cfg_in = '{f, wd, pd, tf, tm};
        cfg_load_in = 1'b1;
        cyc(1);
        cfg_load_in = 1'b0;
        cmp_cfg(cfg_out, cfg_in);
        cyc(3);
        base = rx_count;
    endtask

    task automatic tick();
        cyc(1);
        motion_in.step_tick = 1'b1;
        cyc(1);
        motion_in.step_tick = 1'b0;
    endtask

    // hang guard
    initial begin
        #800000;
        failures++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        resetn_in = 1'b0;
        cfg_load_in = 1'b0;
        cfg_in = '0;
        motion_in = '0;
        failures = 0;
        n_tests = 0;
        seed = 32'he24002c6;
        repeat (20) @(posedge sys_clk_in);
        cyc(1);
        resetn_in = 1'b1;
        cmp_cfg(cfg_out, '{`SO_DEF_FLAGS, `SO_DEF_WIDTH, `SO_DEF_PERIOD,
                `SO_DEF_TOL_FULL, `SO_DEF_TOL_MICRO});
        cmp_bit(sync_out_pin_out, 1'b0);
        // fixed level wins over a firing trigger while follow is clear
        for (int i = 0; i < 4; i++) begin
            load(8'h10 | 8'(i << 1), 16'h0008, 16'h0001, 32'h0, 8'h00);
            motion_in.moving = 1'b1;
            cyc(3);
            cmp_bit(sync_out_pin_out, i[0]);
            motion_in.moving = 1'b0;
            cyc(2);
        end
        // let the last microsecond pulse run out: in step units it would
        // freeze, since no step ticks arrive
        cyc(8 * US + 4);
        // step counted width, active low, merged retrigger
        seed = xorshift(seed);
        w = 3 + int'(seed[1:0]);
        load(8'h1d, 16'(w), 16'h0001, 32'h0, 8'h00);
        cmp_bit(sync_out_pin_out, 1'b1);
        motion_in.moving = 1'b1;
        cyc(3);
        cmp_bit(pulse_active_out, 1'b1);
        cmp_bit(sync_out_pin_out, 1'b0);
        tick();
        tick();
        motion_in.moving = 1'b0;
        cyc(1);
        motion_in.moving = 1'b1;
        cyc(2);
        n = 0;
        while (pulse_active_out === 1'b1 && n < 20) begin
            tick();
            n++;
        end
        cmp_cnt(n, w);
        cyc(3);
        cmp_cnt(rx_count - base, 1);
        motion_in.moving = 1'b0;
        cyc(3);
        cmp_bit(pulse_active_out, 1'b0);
        // microsecond counted width
        seed = xorshift(seed);
        w = 2 + int'(seed[3:2] % 3);
        load(8'h11, 16'(w), 16'h0001, 32'h0, 8'h00);
        motion_in.moving = 1'b1;
        cyc(1);
        n = 0;
        while (pulse_active_out === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        cmp_bit(n > (w - 1) * US && n <= w * US, 1'b1);
        motion_in.moving = 1'b0;
        // periodic pulses every p steps
        seed = xorshift(seed);
        p = 2 + int'(seed[5:4]);
        load(8'h41, 16'h0001, 16'(p), 32'h0, 8'h00);
        repeat (3 * p) begin
            tick();
            cyc(3 * US);
        end
        cmp_cnt(rx_count - base, 3);
        // arrival window: 1 full step of 4 microsteps plus 1 microstep
        load(8'h01, 16'h0001, 16'h0001, 32'h1, 8'h01);
        motion_in.is_stepper = 1'b1;
        motion_in.step_division_mode = 4'h2;
        motion_in.target_full = 32'sd100;
        motion_in.moving = 1'b1;
        cyc(2);
        load(8'h21, 16'h0001, 16'h0001, 32'h1, 8'h01);
        motion_in.pos_full = 32'sd98;
        motion_in.pos_micro = 16'sd2;
        cyc(8);
        cmp_cnt(rx_count - base, 0);
        motion_in.pos_micro = 16'sd3;
        cyc(8);
        cmp_cnt(rx_count - base, 1);
        motion_in.moving = 1'b0;
        cyc(8);
        cmp_cnt(rx_count - base, 2);
        end_of_test();
    end
endmodule
